/* File: src/vtr_regs.sv */
`timescale 1ns/1ps
// Behaviour
// (R1) Low trim nibble shifts reported input current from -2.0 A to +1.75 A.
// (R2) Trim offset is added to the converted current without clamping at zero.
// (R3) Negative sum wraps to full-scale limit minus the shortfall.
// (R4) Host avoids negative trim codes 0000b-0111b when input current may be zero.
// (R5) Host target byte drives the output only while source select equals 10b.
// (R6) Target changes ramp at one quarter of the fast slew rate.
// (R7) Target step is 5 mV or 10 mV per code per protocol field.
// (R8) Target writes NACKed during soft-start/stop, ACKed after soft-start.
// (R9) New target during a ramp redirects the ramp at the next ramp tick.
// (R10) Read-only byte holds last commanded level, boot level included, either path.
// (R11) Last level excludes all offsets and follows the bus-side level register.
// (R12) Last-level readback refreshes every 190 us.
// (R13) Signed host offset adds to the target and ramps at quarter fast rate.
// (R14) Protocol 01b/10b: offset 0.5 mV per code, -64 to +63.5 mV.
// (R15) Protocol 00b/11b: offset 1.0 mV per code, -128 to +127 mV.
// (R16) Effective target is code plus signed offset; bytes update whole at write end.
module vtr_regs
  import vtr_pkg::*;
#(
  parameter int REFRESH_CYC = VTR_REFRESH_CYC,  // Readback refresh period
  parameter int IIN_W       = 10                // Input current word width
) (
  input  wire logic             clk_i,             // 25 MHz clock
  input  wire logic             nrst_i,            // Sync reset, active low
  input  wire logic             cmd_valid_i,       // Byte transaction request
  input  wire logic             cmd_write_i,       // 1 write byte, 0 read byte
  input  wire logic [7:0]       cmd_code_i,        // Command code
  input  wire logic [7:0]       cmd_wdata_i,       // Write data byte
  output logic                  resp_valid_o,      // Answer strobe
  output logic                  resp_ack_o,        // 1 ACK, 0 NACK
  output logic      [7:0]       resp_rdata_o,      // Read data byte
  input  wire logic [1:0]       user_system_config_i,    // Output source select
  input  wire logic [1:0]       voltage_step_protocol_i, // Step protocol field
  input  wire logic [7:0]       ramp_rate_config_i,      // Fast slew, hmV per us
  input  wire logic             soft_ramp_busy_i,  // Soft-start or soft-stop active
  input  wire logic [7:0]       boot_level_i,      // Boot level code
  input  wire logic             vid_cmd_valid_i,   // Bus-side level command pulse
  input  wire logic [7:0]       vid_cmd_code_i,    // Bus-side level code
  input  wire logic [IIN_W-1:0] adc_iin_i,         // Converted input current
  input  wire logic [IIN_W-1:0] input_current_full_scale_i, // Wrap limit
  output logic      [IIN_W-1:0] input_current_report_o,     // Trimmed current
  output logic      [15:0]      vout_target_o,     // Effective target, hmV
  output logic      [15:0]      vout_ramp_o        // Ramped reference, hmV
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0]  target_code;
  logic [7:0]  offset_code;
  logic [7:0]  trim_reg;
  logic [7:0]  last_level;       // live last command
  logic [7:0]  level_readback;   // refreshed snapshot
  logic        boot_taken;
  logic        wr_ok;
  logic        wr_target;
  logic [12:0] refresh_cnt;
  logic [6:0]  ramp_cnt;
  logic        ramp_tick;
  logic [7:0]  cmd_code_sel;
  logic [4:0]  step_hmv;
  logic [1:0]  ofs_hmv;
  logic [15:0] next_target;
  logic [15:0] ramp_diff;
  logic        step_5mv;

  // Write acceptance; the target refuses writes while soft ramps run
  assign wr_target = cmd_valid_i && cmd_write_i && (cmd_code_i == VTR_CMD_TARGET);
  always_comb begin
    wr_ok = 1'b0;
    if (cmd_code_i == VTR_CMD_TARGET) begin
      wr_ok = !soft_ramp_busy_i;  // see (R8)
    end else if (cmd_code_i == VTR_CMD_OFFSET) begin
      wr_ok = 1'b1;
    end else if (cmd_code_i == VTR_CMD_TRIM) begin
      wr_ok = 1'b1;
    end
  end

  // Whole-byte update at the end of the write
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      target_code <= VTR_TARGET_RST;
      offset_code <= VTR_OFFSET_RST;
      trim_reg    <= VTR_TRIM_RST;
    end else if (cmd_valid_i && cmd_write_i && wr_ok) begin
      if (cmd_code_i == VTR_CMD_TARGET) begin
        target_code <= cmd_wdata_i;  // see (R16)
      end else if (cmd_code_i == VTR_CMD_OFFSET) begin
        offset_code <= cmd_wdata_i;  // see (R16)
      end else if (cmd_code_i == VTR_CMD_TRIM) begin
        trim_reg    <= cmd_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  // Unknown codes and writes to the read-only byte answer NACK
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      resp_valid_o <= 1'b0;
      resp_ack_o   <= 1'b0;
      resp_rdata_o <= 8'h00;
    end else begin
      resp_valid_o <= cmd_valid_i;
      resp_ack_o   <= 1'b0;
      resp_rdata_o <= 8'h00;
      if (cmd_valid_i && cmd_write_i) begin
        resp_ack_o <= wr_ok;
      end else if (cmd_valid_i) begin
        resp_ack_o <= 1'b1;
        if (cmd_code_i == VTR_CMD_TARGET) begin
          resp_rdata_o <= target_code;
        end else if (cmd_code_i == VTR_CMD_LEVEL) begin
          resp_rdata_o <= level_readback;  // see (R10)
        end else if (cmd_code_i == VTR_CMD_OFFSET) begin
          resp_rdata_o <= offset_code;
        end else if (cmd_code_i == VTR_CMD_TRIM) begin
          resp_rdata_o <= trim_reg;
        end else begin
          resp_ack_o <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Last commanded level
  // ----------------------------------------------------------------
  // Boot code caught one edge after reset release, then either path
  // overwrites; offsets never enter this byte
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      last_level <= 8'h00;
      boot_taken <= 1'b0;
    end else if (!boot_taken) begin
      last_level <= boot_level_i;  // see (R10)
      boot_taken <= 1'b1;
    end else if (vid_cmd_valid_i) begin
      last_level <= vid_cmd_code_i;  // see (R11)
    end else if (wr_target && wr_ok && user_system_config_i == VTR_SRC_HOST) begin
      last_level <= cmd_wdata_i;  // see (R11)
    end
  end

  // Periodic snapshot; reads see a value at most one period old
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      refresh_cnt    <= 13'h0000;
      level_readback <= 8'h00;
    end else if (refresh_cnt == 13'(REFRESH_CYC - 1)) begin
      refresh_cnt    <= 13'h0000;
      level_readback <= last_level;  // see (R12)
    end else begin
      refresh_cnt    <= refresh_cnt + 13'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Effective target
  // ----------------------------------------------------------------
  // Offset weight and target step follow the protocol field
  always_comb begin
    step_5mv = (voltage_step_protocol_i == 2'h1) || (voltage_step_protocol_i == 2'h2);
    step_hmv = step_5mv ? VTR_STEP5_HMV : VTR_STEP10_HMV;  // see (R7)
    ofs_hmv  = step_5mv ? VTR_OFS5_HMV : VTR_OFS10_HMV;    // see (R14) see (R15)
  end

  assign cmd_code_sel = (user_system_config_i == VTR_SRC_HOST) ? target_code : last_level; // see (R5)

  // Code times step plus signed offset times its weight
  always_comb begin
    next_target = 16'({8'h00, cmd_code_sel} * {11'h000, step_hmv})
                + 16'($signed({{8{offset_code[7]}}, offset_code}) * $signed({14'h0000, ofs_hmv})); // see (R13)
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      vout_target_o <= 16'h0000;
    end else begin
      vout_target_o <= next_target;  // see (R16)
    end
  end

  // ----------------------------------------------------------------
  // Quarter-rate ramp
  // ----------------------------------------------------------------
  // One step per four slew-rate intervals
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ramp_cnt <= 7'h00;
    end else if (ramp_tick) begin
      ramp_cnt <= 7'h00;
    end else begin
      ramp_cnt <= ramp_cnt + 7'h01;
    end
  end
  assign ramp_tick = (ramp_cnt == 7'(VTR_RAMP_CYC - 1));  // see (R6)

  // Ramp chases the current target, so a new write redirects it at the next ramp tick
  assign ramp_diff = (vout_target_o > vout_ramp_o) ? vout_target_o - vout_ramp_o
                                                    : vout_ramp_o - vout_target_o;
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      vout_ramp_o <= 16'h0000;
    end else if (ramp_tick) begin
      if (ramp_diff <= {8'h00, ramp_rate_config_i}) begin
        vout_ramp_o <= vout_target_o;  // see (R9)
      end else if (vout_target_o > vout_ramp_o) begin
        vout_ramp_o <= vout_ramp_o + {8'h00, ramp_rate_config_i};  // see (R6) see (R13)
      end else begin
        vout_ramp_o <= vout_ramp_o - {8'h00, ramp_rate_config_i};  // see (R9)
      end
    end
  end

  // ----------------------------------------------------------------
  // Input current trim
  // ----------------------------------------------------------------
  // Quarter-amp trim, code 1000b is zero; no clamp, negatives wrap
  // below full scale. Codes under 1000b are the host's risk.
  logic signed [IIN_W+1:0] iin_sum;
  always_comb begin
    iin_sum = $signed({2'b00, adc_iin_i})
            + $signed((IIN_W+2)'($signed({1'b0, trim_reg[VTR_TRIM_LSB +: VTR_TRIM_W]})
                                 - $signed({1'b0, VTR_TRIM_ZERO}))); // see (R1) see (R2) see (R4)
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      input_current_report_o <= '0;
    end else if (iin_sum < 0) begin
      input_current_report_o <= IIN_W'($signed({2'b00, input_current_full_scale_i}) + iin_sum); // see (R3)
    end else begin
      input_current_report_o <= iin_sum[IIN_W-1:0];  // see (R2)
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_nack_soft;
    @(posedge clk_i) disable iff (!nrst_i)
      (cmd_valid_i && cmd_write_i && cmd_code_i == VTR_CMD_TARGET && soft_ramp_busy_i)
      |=> resp_valid_o && !resp_ack_o;
  endproperty
  a_nack_soft: assert property (p_nack_soft) else $error("target write not refused in soft ramp"); // see (R8)

  property p_ack_after;
    @(posedge clk_i) disable iff (!nrst_i)
      (cmd_valid_i && cmd_write_i && cmd_code_i == VTR_CMD_TARGET && !soft_ramp_busy_i)
      |=> resp_ack_o && target_code == $past(cmd_wdata_i);
  endproperty
  a_ack_after: assert property (p_ack_after) else $error("target write lost"); // see (R8)

  property p_keep_target;
    @(posedge clk_i) disable iff (!nrst_i)
      (cmd_valid_i && cmd_write_i && cmd_code_i == VTR_CMD_TARGET && soft_ramp_busy_i)
      |=> $stable(target_code);
  endproperty
  a_keep_target: assert property (p_keep_target) else $error("refused write changed target"); // see (R8)

  property p_refresh;
    @(posedge clk_i) disable iff (!nrst_i)
      refresh_cnt == 13'(REFRESH_CYC - 1) |=> level_readback == $past(last_level);
  endproperty
  a_refresh: assert property (p_refresh) else $error("readback not refreshed"); // see (R12)

  property p_ro_level;
    @(posedge clk_i) disable iff (!nrst_i)
      (refresh_cnt != 13'(REFRESH_CYC - 1)) |=> $stable(level_readback);
  endproperty
  a_ro_level: assert property (p_ro_level) else $error("readback moved between refreshes"); // see (R10)

  property p_host_src;
    @(posedge clk_i) disable iff (!nrst_i)
      (user_system_config_i == VTR_SRC_HOST && offset_code == 8'h00 && step_5mv)
      |=> vout_target_o == 16'($past(target_code) * 10);
  endproperty
  a_host_src: assert property (p_host_src) else $error("host target not applied"); // see (R5)

  property p_ofs_weight;
    @(posedge clk_i) disable iff (!nrst_i)
      (!step_5mv && user_system_config_i == VTR_SRC_HOST && target_code == 8'h00 && offset_code == 8'hFF)
      |=> vout_target_o == 16'hFFFE;
  endproperty
  a_ofs_weight: assert property (p_ofs_weight) else $error("offset weight wrong"); // see (R15)

  property p_ramp_step;
    @(posedge clk_i) disable iff (!nrst_i)
      ramp_tick && vout_target_o > vout_ramp_o && ramp_diff > {8'h00, ramp_rate_config_i}
      |=> vout_ramp_o == $past(vout_ramp_o) + {8'h00, $past(ramp_rate_config_i)};
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("ramp step wrong"); // see (R6)

  property p_ramp_hold;
    @(posedge clk_i) disable iff (!nrst_i)
      ramp_tick |=> !ramp_tick [*3] ##1 $stable(vout_ramp_o);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold) else $error("ramp moved between ticks"); // see (R6)

  property p_wrap;
    @(posedge clk_i) disable iff (!nrst_i)
      (iin_sum < 0) |=> input_current_report_o
                        == IIN_W'($signed({2'b00, $past(input_current_full_scale_i)}) + $past(iin_sum));
  endproperty
  a_wrap: assert property (p_wrap) else $error("negative current not wrapped"); // see (R3)

  property p_trim_zero;
    @(posedge clk_i) disable iff (!nrst_i)
      // Release edge skipped: the report still carries its reset value there
      nrst_i && trim_reg[3:0] == VTR_TRIM_ZERO |=> input_current_report_o == $past(adc_iin_i);
  endproperty
  a_trim_zero: assert property (p_trim_zero) else $error("zero trim shifted current"); // see (R1)

endmodule : vtr_regs

/* File: src/vtr_pkg.sv */
package vtr_pkg;
  // ----------------------------------------------------------------
  // Command codes of the byte registers
  // ----------------------------------------------------------------
  localparam logic [7:0] VTR_CMD_TRIM   = 8'hA5;  // input_current_trim
  localparam logic [7:0] VTR_CMD_TARGET = 8'hA6;  // output_voltage_target
  localparam logic [7:0] VTR_CMD_LEVEL  = 8'hA7;  // last_commanded_level
  localparam logic [7:0] VTR_CMD_OFFSET = 8'hA8;  // host_voltage_offset

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         VTR_TRIM_LSB   = 0;      // offset trim nibble
  localparam int         VTR_TRIM_W     = 4;
  localparam logic [3:0] VTR_TRIM_ZERO  = 4'h8;   // code of zero offset
  localparam logic [7:0] VTR_TRIM_RST   = 8'h08;
  localparam logic [7:0] VTR_TARGET_RST = 8'h00;
  localparam logic [7:0] VTR_OFFSET_RST = 8'h00;
  localparam logic [1:0] VTR_SRC_HOST   = 2'h2;   // source select: host byte

  // Target and offset weights in half-millivolt units
  localparam logic [4:0] VTR_STEP5_HMV  = 5'h0A;  // 5 mV per code
  localparam logic [4:0] VTR_STEP10_HMV = 5'h14;  // 10 mV per code
  localparam logic [1:0] VTR_OFS5_HMV   = 2'h1;   // 0.5 mV per offset code
  localparam logic [1:0] VTR_OFS10_HMV  = 2'h2;   // 1.0 mV per offset code

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int VTR_CLK_KHZ      = 25000;                           // 25 MHz
  localparam int VTR_REFRESH_US   = 190;                             // readback refresh
  localparam int VTR_REFRESH_CYC  = VTR_REFRESH_US * VTR_CLK_KHZ / 1000;
  localparam int VTR_SLEW_NS      = 1000;                            // slew rate unit
  localparam int VTR_SLEW_CYC     = VTR_SLEW_NS * VTR_CLK_KHZ / 1000000;
  localparam int VTR_QUARTER      = 4;                               // quarter of fast rate
  localparam int VTR_RAMP_CYC     = VTR_SLEW_CYC * VTR_QUARTER;
endpackage : vtr_pkg

/* File: tb/vtr_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host controller model: single byte write and read requests
// ----------------------------------------------------------------
module vtr_host_model (
  input  wire logic       clk_i,        // Bench clock
  output logic            cmd_valid_o,  // Request strobe
  output logic            cmd_write_o,  // 1 write, 0 read
  output logic      [7:0] cmd_code_o,   // Command code
  output logic      [7:0] cmd_wdata_o   // Write byte
);
  // Idle bus from time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o  = 8'h00;
    cmd_wdata_o = 8'h00;
  end

  // Raise one request; it is taken at the following edge
  task automatic req(input logic w, input logic [7:0] code, input logic [7:0] data);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= w;
    cmd_code_o  <= code;
    cmd_wdata_o <= data;
  endtask : req

  // Release after the taking edge; stale code and data lines are inverted, the write line is held
  task automatic rel();
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_code_o  <= ~cmd_code_o;
    cmd_wdata_o <= ~cmd_wdata_o;
  endtask : rel
endmodule : vtr_host_model

/* File: tb/vtr_regs_tb_top.sv */
`timescale 1ns/1ps
module vtr_regs_tb_top
  import vtr_pkg::*;
;
  localparam int RCYC = 20;  // Short refresh keeps the run brief
  logic clk_i, nrst_i, cmd_valid, cmd_write, resp_valid, resp_ack, ramp_busy, vid_valid;
  logic [7:0] cmd_code, cmd_wdata, resp_rdata, ramp_rate, boot_level, vid_code, c, o, d;
  logic [1:0] src_sel, step_proto;
  logic [9:0] adc_iin, iin_fs, iin_report, exp_e;
  logic [15:0] vout_target, vout_ramp, v, lfsr;
  logic [9:0] exp_q[$];
  int fail_count, num_checks;

  // ----------------------------------------------------------------
  // Clock, host and block
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  vtr_host_model i_host (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
    .cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata));

  vtr_regs #(.REFRESH_CYC(RCYC), .IIN_W(10)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_code_i(cmd_code),
    .cmd_wdata_i(cmd_wdata), .resp_valid_o(resp_valid), .resp_ack_o(resp_ack),
    .resp_rdata_o(resp_rdata), .user_system_config_i(src_sel),
    .voltage_step_protocol_i(step_proto), .ramp_rate_config_i(ramp_rate),
    .soft_ramp_busy_i(ramp_busy), .boot_level_i(boot_level), .vid_cmd_valid_i(vid_valid),
    .vid_cmd_code_i(vid_code), .adc_iin_i(adc_iin), .input_current_full_scale_i(iin_fs),
    .input_current_report_o(iin_report), .vout_target_o(vout_target), .vout_ramp_o(vout_ramp));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : rnd

  // Effective target in half-mV: fine steps for protocol 01b and 10b
  function automatic logic [15:0] eff(input logic [1:0] p, input logic [7:0] cc, input logic [7:0] oo);
    logic fine;
    fine = (p == 2'h1) || (p == 2'h2);
    return 16'(int'(cc) * (fine ? 10 : 20) + int'($signed(oo)) * (fine ? 1 : 2));
  endfunction : eff

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: value got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: response got %h expected %h", $time, got, exp);
    end
  endtask : chk_resp

  // Note the expected answer, then issue the request
  task automatic bus(input logic w, input logic [7:0] code, input logic [7:0] dd, input logic ack,
                     input logic [7:0] rd);
    exp_q.push_back({~w, ack, rd});
    i_host.req(w, code, dd);
  endtask : bus

  task automatic close_out();
    if (exp_q.size() != 0) fail_count++;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // Answer monitor; read data only matters on reads
  always @(posedge clk_i) begin
    if (resp_valid === 1'b1) begin
      // An answer with no note never matches: its ack bit is inverted
      exp_e = (exp_q.size() > 0) ? exp_q.pop_front() : {1'b1, ~resp_ack, 8'h00};
      chk_resp({exp_e[9], resp_ack, exp_e[9] ? resp_rdata : exp_e[7:0]}, exp_e);
    end
  end

  // Watchdog well beyond the expected run of about 1100 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    lfsr = 16'hC06D;
    fail_count = 0;
    num_checks = 0;
    nrst_i = 1'b0;
    ramp_busy = 1'b0;
    vid_valid = 1'b0;
    vid_code = 8'h00;
    src_sel = VTR_SRC_HOST;
    step_proto = 2'h0;
    ramp_rate = 8'h0A;
    boot_level = rnd();
    adc_iin = 10'h010;
    iin_fs = 10'h280;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (RCYC + 5) @(posedge clk_i);
    bus(1'b0, VTR_CMD_TRIM, 8'h00, 1'b1, VTR_TRIM_RST);
    bus(1'b0, VTR_CMD_TARGET, 8'h00, 1'b1, VTR_TARGET_RST);
    bus(1'b0, VTR_CMD_OFFSET, 8'h00, 1'b1, VTR_OFFSET_RST);
    bus(1'b0, VTR_CMD_LEVEL, 8'h00, 1'b1, boot_level);
    bus(1'b1, VTR_CMD_LEVEL, 8'h12, 1'b0, 8'h00);
    bus(1'b1, 8'hA9, 8'h12, 1'b0, 8'h00);
    bus(1'b0, 8'hA9, 8'h00, 1'b0, 8'h00);
    // Back-to-back write then read of random bytes
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      bus(1'b1, VTR_CMD_OFFSET, d, 1'b1, 8'h00);
      bus(1'b0, VTR_CMD_OFFSET, 8'h00, 1'b1, d);
    end
    i_host.rel();
    $display("Test access done");
    // Writes refused during soft ramp, taken after it
    @(posedge clk_i);
    ramp_busy <= 1'b1;
    bus(1'b1, VTR_CMD_TARGET, 8'h55, 1'b0, 8'h00);
    bus(1'b0, VTR_CMD_TARGET, 8'h00, 1'b1, VTR_TARGET_RST);
    i_host.rel();
    ramp_busy <= 1'b0;
    bus(1'b1, VTR_CMD_TARGET, 8'h55, 1'b1, 8'h00);
    i_host.rel();
    $display("Test soft ramp done");
    // Every protocol setting with random code and signed offset
    for (int p = 0; p < 4; p++) begin
      c = rnd() | 8'h80;
      o = rnd();
      @(posedge clk_i);
      step_proto <= 2'(p);
      bus(1'b1, VTR_CMD_TARGET, c, 1'b1, 8'h00);
      bus(1'b1, VTR_CMD_OFFSET, o, 1'b1, 8'h00);
      i_host.rel();
      repeat (3) @(negedge clk_i);
      chk_val(vout_target, eff(2'(p), c, o));
    end
    $display("Test protocols done");
    // Level readback: host code, other path, and no host write when not selected
    repeat (RCYC + 5) @(posedge clk_i);
    bus(1'b0, VTR_CMD_LEVEL, 8'h00, 1'b1, c);
    i_host.rel();
    d = rnd();
    vid_valid <= 1'b1;
    vid_code <= d;
    @(posedge clk_i);
    vid_valid <= 1'b0;
    src_sel <= 2'h0;
    vid_code <= ~d;
    bus(1'b1, VTR_CMD_TARGET, ~d, 1'b1, 8'h00);
    i_host.rel();
    repeat (RCYC + 5) @(posedge clk_i);
    bus(1'b0, VTR_CMD_LEVEL, 8'h00, 1'b1, d);
    i_host.rel();
    src_sel <= VTR_SRC_HOST;
    $display("Test level readback done");
    // Trim codes on a current that never reaches zero
    for (int t = 0; t < 16; t++) begin
      @(posedge clk_i);
      adc_iin <= 10'(rnd()) + 10'h008;
      bus(1'b1, VTR_CMD_TRIM, 8'(t), 1'b1, 8'h00);
      i_host.rel();
      repeat (3) @(negedge clk_i);
      chk_val(16'(iin_report), 16'(adc_iin + 10'(t) - 10'h008));
    end
    // Negative sum wraps below the full-scale limit
    @(posedge clk_i);
    adc_iin <= 10'h002;
    bus(1'b1, VTR_CMD_TRIM, 8'h04, 1'b1, 8'h00);
    i_host.rel();
    repeat (3) @(negedge clk_i);
    chk_val(16'(iin_report), 16'(iin_fs - 10'h002));
    $display("Test current trim done");
    // Zero code with an offset of minus one on 1 mV steps wraps the target
    @(posedge clk_i);
    bus(1'b1, VTR_CMD_TARGET, 8'h00, 1'b1, 8'h00);
    bus(1'b1, VTR_CMD_OFFSET, 8'hFF, 1'b1, 8'h00);
    i_host.rel();
    repeat (3) @(negedge clk_i);
    chk_val(vout_target, eff(2'h3, 8'h00, 8'hFF));
    // Ramp: quarter of rate per us, so 16 us moves four times the rate
    @(posedge clk_i);
    // Fine steps with zero offset here, so the host-source check is exercised
    step_proto <= 2'h1;
    bus(1'b1, VTR_CMD_OFFSET, 8'h00, 1'b1, 8'h00);
    bus(1'b1, VTR_CMD_TARGET, 8'hC8, 1'b1, 8'h00);
    i_host.rel();
    repeat (3) @(negedge clk_i);
    v = vout_ramp;
    repeat (400) @(negedge clk_i);
    chk_val(vout_ramp, v + 16'(ramp_rate) * 16'h0004);
    @(posedge clk_i);
    bus(1'b1, VTR_CMD_TARGET, 8'h00, 1'b1, 8'h00);
    i_host.rel();
    repeat (3) @(negedge clk_i);
    v = vout_ramp;
    repeat (400) @(negedge clk_i);
    chk_val(vout_ramp, v - 16'(ramp_rate) * 16'h0004);
    $display("Test ramp done");
    close_out();
  end
endmodule : vtr_regs_tb_top
